// ---- include/cms_pkg.sv ----
// Shared types and constants for the configuration mode sequencer.
// Assumes a single 100 MHz clock domain and no software registers.
package cms_pkg;

  // Clock period in ns
  localparam int CLK_PERIOD_NS = 10;
  // Longest permitted load time in ms, as a cycle count
  localparam int LOAD_LIMIT_MS = 100;
  localparam int LOAD_LIMIT_CYC = (LOAD_LIMIT_MS * 1000000) / CLK_PERIOD_NS;
  // Initialization phase length in cycles
  localparam int INIT_CYC = 8;
  // Default configuration image size in bytes
  localparam int IMAGE_BYTES = 1024;

  // Data source selection
  typedef enum logic [2:0] {
    CMS_SCHEME_MEMORY = 3'h0,
    CMS_SCHEME_SERIAL = 3'h1,
    CMS_SCHEME_PAR_ASYNC = 3'h2,
    CMS_SCHEME_FAST_PAR = 3'h3,
    CMS_SCHEME_JTAG = 3'h4
  } cms_scheme_e;

  // Sequencer states
  typedef enum logic [2:0] {
    CMS_POWERUP,
    CMS_LOAD,
    CMS_INIT,
    CMS_USER,
    CMS_ERROR
  } cms_state_e;

  // One configuration byte on its way to the array
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } cms_word_s;

endpackage : cms_pkg

// ---- design/cms_skid_buffer.sv ----
// Two-entry buffer with valid/ready on both sides.
// Assumes the producer and consumer share one clock.
`timescale 1ns/10ps
`default_nettype none
module cms_skid_buffer
  import cms_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire cms_word_s in_word,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output cms_word_s out_word
);

  cms_word_s slot [2]; // Storage, slot 0 is the head
  logic [1:0] count; // Words held
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_word = slot[0];

  // Shift on pop, write behind the last held word on push
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      count <= 2'h0;
      slot[0] <= '0;
      slot[1] <= '0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        slot[0] <= slot[1];
      end
      if (push) begin
        if (pop) begin
          if (count == 2'h1) slot[0] <= in_word;
          else slot[1] <= in_word;
        end else if (count == 2'h0) begin
          slot[0] <= in_word;
        end else begin
          slot[1] <= in_word;
        end
      end
    end
  end

endmodule : cms_skid_buffer
`default_nettype wire

// ---- design/cms_sequencer.sv ----
// Configuration mode sequencer: power-up, load, init and user mode.
// Assumes byte streams already framed by pin front-ends on ref_clk;
// the reconfiguration and chain pins arrive asynchronously.
//
// What this block does
// - Every power-up needs a full load first.
// - Init follows load: reset; pins enable only after it, in user mode.
// - Pins high impedance before and during load.
// - Load plus init is command mode.
// - User pins weakly pulled high before user.
// - Reconfig pin returns device to command mode.
// - Exactly one selected scheme supplies data.
// - Chain enable out feeds next enable in.
// - Byte per cycle; load within limit.
// - Host writes bytes to one location.
// - Memory scheme loads automatically at power-up.
// - JTAG pulse acts like reconfig pin.
// - I/O setup instruction aborts ongoing load.
`timescale 1ns/10ps
`default_nettype none
module cms_sequencer
  import cms_pkg::*;
#(
  parameter int IMAGE_LEN = IMAGE_BYTES, // Bytes in one image
  parameter int LOAD_LIMIT = LOAD_LIMIT_CYC // Load timeout in cycles
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Device pins; the two inputs are asynchronous, chain out is registered
  input wire logic reconfig_request_n,
  input wire logic chain_enable_in_n,
  output logic chain_enable_out_n,
  // Scheme select, fixed by board straps
  input wire cms_scheme_e scheme,
  // Byte sources, one per scheme
  input wire logic [4:0] src_valid,
  input wire logic [39:0] src_data,
  output logic [4:0] src_ready,
  // JTAG instruction strobes
  input wire logic pulse_reconfig_instruction,
  input wire logic io_setup_instruction,
  // Configuration array write port
  output logic cfg_wr,
  output logic [7:0] cfg_data,
  output logic [31:0] cfg_addr,
  // User logic and pin control
  output logic user_mode,
  output logic init_reset,
  output logic io_enable,
  output logic io_weak_pullup,
  output logic load_error
);

  cms_state_e state, next_state;
  logic [1:0] reconfig_sync; // Pin synchroniser
  logic [1:0] chain_sync; // Pin synchroniser
  logic [31:0] byte_count; // Bytes accepted this load
  logic [31:0] timer; // Load time so far
  logic [3:0] init_count; // Init phase length
  cms_word_s in_word, buf_word;
  logic in_valid, in_ready, buf_valid, buf_ready;

  // Synchronised pins; only stage 1 is read by logic
  wire logic reconfig_req = !reconfig_sync[1] || pulse_reconfig_instruction;
  wire logic chain_on = !chain_sync[1];
  wire logic loading = (state == CMS_LOAD);
  wire logic last_byte = (byte_count == 32'(IMAGE_LEN - 1));
  // Stop taking once the image is in, so no stray byte is stranded in the buffer
  wire logic want_more = (byte_count < 32'(IMAGE_LEN));
  wire logic got_all = buf_valid && buf_ready && buf_word.last;
  wire logic timed_out = (timer == 32'(LOAD_LIMIT));
  wire logic [2:0] sel = scheme;

  // Select the one active source; others see no ready
  assign in_valid = loading && chain_on && want_more && src_valid[sel];
  assign in_word.data = src_data[sel*8 +: 8];
  assign in_word.last = last_byte;

  // Ready only to the selected scheme, and only while enabled
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_ready
      assign src_ready[g] = loading && chain_on && want_more && in_ready && (sel == 3'(g));
    end
  endgenerate

  // Back-pressure path into the array writer
  cms_skid_buffer u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_word(in_word),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_word(buf_word)
  );
  assign buf_ready = 1'b1; // Array accepts one byte per cycle

  // Pin outputs follow mode: tri-state and pull-up until user mode
  assign user_mode = (state == CMS_USER);
  assign io_enable = user_mode;
  assign io_weak_pullup = !user_mode;
  assign init_reset = (state == CMS_INIT);

  // Next-state decision
  always_comb begin
    next_state = state;
    unique case (state)
      CMS_POWERUP: next_state = CMS_LOAD;
      CMS_LOAD: begin
        if (io_setup_instruction || timed_out) next_state = CMS_ERROR;
        else if (got_all) next_state = CMS_INIT;
      end
      CMS_INIT: begin
        if (init_count == 4'(INIT_CYC - 1)) next_state = CMS_USER;
      end
      CMS_USER: ;
      CMS_ERROR: ;
    endcase
    // Reconfig request overrides everything
    if (reconfig_req) next_state = CMS_POWERUP;
  end

  // Synchronisers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reconfig_sync <= 2'h3;
      chain_sync <= 2'h3;
    end else begin
      reconfig_sync <= {reconfig_sync[0], reconfig_request_n};
      chain_sync <= {chain_sync[0], chain_enable_in_n};
    end
  end

  // State register; reset always means a fresh load
  always_ff @(posedge ref_clk) begin
    if (!resetn) state <= CMS_POWERUP;
    else state <= next_state;
  end

  // Byte counter and load timer, restarted outside loading
  always_ff @(posedge ref_clk) begin
    if (!resetn || !loading) begin
      byte_count <= 32'h0;
      timer <= 32'h0;
    end else begin
      if (in_valid && in_ready) byte_count <= byte_count + 32'h1;
      if (!timed_out) timer <= timer + 32'h1;
    end
  end

  // Init phase length
  always_ff @(posedge ref_clk) begin
    if (!resetn || state != CMS_INIT) init_count <= 4'h0;
    else init_count <= init_count + 4'h1;
  end

  // Array write port and address, registered
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_wr <= 1'b0;
      cfg_data <= 8'h00;
      cfg_addr <= 32'h0;
    end else begin
      cfg_wr <= buf_valid && loading;
      cfg_data <= buf_word.data;
      if (!loading) cfg_addr <= 32'h0;
      // Advance after each write so the address stands beside its own byte
      else if (cfg_wr) cfg_addr <= cfg_addr + 32'h1;
    end
  end

  // Chain output: released only once own image is in; error flag
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      chain_enable_out_n <= 1'b1;
      load_error <= 1'b0;
    end else begin
      if (reconfig_req) chain_enable_out_n <= 1'b1;
      else if (got_all && loading) chain_enable_out_n <= 1'b0;
      if (state == CMS_ERROR) load_error <= 1'b1;
      // Cleared in the restart state, so a one-cycle request still clears it
      else if (state == CMS_POWERUP) load_error <= 1'b0;
    end
  end

endmodule : cms_sequencer
`default_nettype wire

// ---- sim/cms_monitor.sv ----
// Assertions on the sequencer ports.
// Assumes one clock; resetn low blanks every check.
`timescale 1ns/10ps
`default_nettype none
module cms_monitor
  import cms_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Watched ports
  input wire cms_scheme_e scheme,
  input wire logic [4:0] src_valid,
  input wire logic [39:0] src_data,
  input wire logic [4:0] src_ready,
  input wire logic pulse_reconfig_instruction,
  input wire logic io_setup_instruction,
  input wire logic chain_enable_out_n,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_data,
  input wire logic user_mode,
  input wire logic init_reset,
  input wire logic io_enable,
  input wire logic io_weak_pullup,
  input wire logic load_error
);
  // Byte on the selected lane and whether it is taken
  wire logic [7:0] sel = src_data[8*scheme +: 8];
  wire logic take = src_valid[scheme] && src_ready[scheme];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_io_tristate: assert property ((|src_ready || cfg_wr || init_reset) |-> !io_enable)
    else $error("io on");
  chk_load_pullup: assert property (|src_ready |-> io_weak_pullup) else $error("no pull");
  chk_one_scheme: assert property ((src_ready & ~(5'h01 << scheme)) == 5'h00)
    else $error("wrong lane ready");
  // An abort may drop a byte in flight, hence the error escape
  chk_write_order: assert property (take |-> ##2 (load_error ||
    (cfg_wr && cfg_data == $past(sel, 2)))) else $error("write lost");
  chk_init_span: assert property ($rose(init_reset) |-> init_reset [*8] ##1 user_mode)
    else $error("init span");
  chk_chain_done: assert property ($fell(chain_enable_out_n) |-> ##[0:6] init_reset)
    else $error("chain early");
  chk_abort_load: assert property (io_setup_instruction && |src_ready |-> ##2 load_error)
    else $error("no abort");
  chk_instr_reload: assert property (pulse_reconfig_instruction |=>
    !user_mode && src_ready == 5'h00) else $error("no reload");
  chk_error_quiet: assert property (load_error |-> !user_mode && src_ready == 5'h00)
    else $error("error busy");
  cover property ($rose(user_mode));
  cover property (take ##1 take);
  cover property ($rose(load_error));
endmodule : cms_monitor
bind cms_sequencer cms_monitor mon (.ref_clk, .resetn, .scheme, .src_valid, .src_data,
  .src_ready, .pulse_reconfig_instruction, .io_setup_instruction, .chain_enable_out_n,
  .cfg_wr, .cfg_data, .user_mode, .init_reset, .io_enable, .io_weak_pullup, .load_error);
`default_nettype wire

// ---- sim/cms_source_model.sv ----
// Byte source on the selected lane; other lanes carry noise.
// Assumes the bench seeds $urandom; slow stalls at random.
`timescale 1ns/10ps
`default_nettype none
module cms_source_model
  import cms_pkg::*;
(
  // Control
  input wire logic ref_clk,
  input wire cms_scheme_e scheme,
  input wire logic slow,
  // Lanes toward the sequencer
  input wire logic [4:0] src_ready,
  output logic [4:0] src_valid,
  output logic [39:0] src_data
);
  logic [7:0] b = 8'hA5; // Byte on offer
  logic v = 1'b0; // Offer pending
  logic took = 1'b0; // Offer taken at last edge
  initial {src_valid, src_data} = '0;
  always @(posedge ref_clk) took <= v && src_ready[scheme];
  // Offer held until taken; idle lane inverts the byte each idle cycle, so every second one shows the stale byte
  always @(negedge ref_clk) begin
    if (took || !v) begin
      v = !slow || $urandom_range(2) == 0;
      b = v ? 8'($urandom) : ~b;
    end
    src_valid = 5'($urandom);
    src_valid[scheme] = v;
    src_data = {8'($urandom), 32'($urandom)};
    src_data[8*scheme +: 8] = b;
  end
endmodule : cms_source_model
`default_nettype wire

// ---- sim/tb.sv ----
// Bench: loads, chain hold, reloads and abort against a byte queue.
// Assumes a 4-byte image; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  import cms_pkg::*;
  logic ref_clk = 0, resetn = 0, reconfig_request_n = 1, chain_enable_in_n = 0, slow = 0;
  logic pulse_reconfig_instruction = 0, io_setup_instruction = 0;
  cms_scheme_e scheme = CMS_SCHEME_MEMORY;
  logic [4:0] src_valid, src_ready;
  logic [39:0] src_data;
  logic chain_enable_out_n, cfg_wr, user_mode, init_reset, io_enable, io_weak_pullup, load_error;
  logic [7:0] cfg_data;
  logic [7:0] exp_b; // Expected byte of the current write
  logic [31:0] cfg_addr;
  int n_init = 0, ibase = 0; // Cycles seen in init, and count at load start
  logic [7:0] q[$]; // Taken bytes awaiting their write
  int n_errors = 0, check_count = 0, n_wr = 0, cyc = 0, base;
  always #5 ref_clk = ~ref_clk;
  cms_source_model src (.ref_clk, .scheme, .slow, .src_ready, .src_valid, .src_data);
  cms_sequencer #(.IMAGE_LEN(4), .LOAD_LIMIT(500)) dut (.ref_clk, .resetn, .reconfig_request_n,
    .chain_enable_in_n, .chain_enable_out_n, .scheme, .src_valid, .src_data, .src_ready,
    .pulse_reconfig_instruction, .io_setup_instruction, .cfg_wr, .cfg_data, .cfg_addr,
    .user_mode, .init_reset, .io_enable, .io_weak_pullup, .load_error);
  // Model: every taken byte reaches the array once, in order
  always @(posedge ref_clk) begin
    if (resetn && src_valid[scheme] && src_ready[scheme]) q.push_back(src_data[8*scheme +: 8]);
    if (init_reset) n_init++;
    if (cfg_wr) begin
      `CHK("queued", 1, q.size() > 0)
      exp_b = q.pop_front();
      `CHK("cfg_data", exp_b, cfg_data)
      `CHK("cfg_addr", n_wr - base, cfg_addr)
      n_wr++;
    end
  end
  // Hang guard
  always @(posedge ref_clk) if (++cyc == 20000) begin
    n_errors++;
    complete_run();
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  // Wait for user mode, then one whole image must have gone in
  task automatic load_done();
    for (int i = 0; i < 400 && user_mode !== 1'b1; i++) tick(1);
    `CHK("user", 1'b1, user_mode)
    `CHK("bytes", 4, n_wr - base)
    `CHK("chain", 1'b0, chain_enable_out_n)
    `CHK("init_len", INIT_CYC, n_init - ibase)
    `CHK("io_on", 1'b1, io_enable)
    `CHK("pull_off", 1'b0, io_weak_pullup)
  endtask : load_done
  task automatic reload(input logic pin);
    base = n_wr;
    ibase = n_init;
    reconfig_request_n = !pin;
    pulse_reconfig_instruction = !pin;
    tick(4);
    `CHK("command", 1'b0, user_mode)
    reconfig_request_n = 1;
    pulse_reconfig_instruction = 0;
  endtask : reload
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(32'heed2));
    // Every scheme loads from power-up; odd passes stall
    for (int s = 0; s < 6; s++) begin
      resetn = 0;
      scheme = cms_scheme_e'(s % 5);
      slow = s[0];
      chain_enable_in_n = (s == 5);
      tick(5);
      `CHK("pullup", 1'b1, io_weak_pullup)
      `CHK("io_off", 1'b0, io_enable)
      base = n_wr;
      ibase = n_init;
      resetn = 1;
      tick(30);
      `CHK("chain_hold", 0, (s == 5) ? n_wr - base : 0)
      chain_enable_in_n = 0;
      load_done();
    end
    reload(1'b1);
    load_done();
    reload(1'b0);
    load_done();
    // Setup instruction mid-load aborts until the next reload
    slow = 1;
    reload(1'b0);
    tick(1 + $urandom_range(2));
    io_setup_instruction = 1;
    tick(1);
    io_setup_instruction = 0;
    tick(20);
    `CHK("abort", 1'b1, load_error)
    q.delete();
    reload(1'b1);
    load_done();
    `CHK("err_clear", 1'b0, load_error)
    // Chain input held off: the load must time out and chain out stay high
    chain_enable_in_n = 1;
    reload(1'b1);
    tick(520);
    `CHK("timeout", 1'b1, load_error)
    `CHK("chain_idle", 1'b1, chain_enable_out_n)
    chain_enable_in_n = 0;
    reload(1'b1);
    load_done();
    complete_run();
  end
endmodule : tb
`default_nettype wire
